// ==== rtl/toggle_cfg.svh ====
// Offsets, field positions and reset values of the indirect toggle access block
`ifndef TOGGLE_CFG_SVH
`define TOGGLE_CFG_SVH

// ----------------------------------------------------------------
// Command register indexes
// ----------------------------------------------------------------
`define CMD_IDX_ADDR_LOW   6'h3a
`define CMD_IDX_ADDR_HIGH  6'h3b
`define CMD_IDX_VALUE      6'h3c
`define CMD_IDX_RESET      6'h00
// Bit of a command address transfer that asks for a read
`define CMD_RD_BIT         6

// ----------------------------------------------------------------
// Extended register map
// ----------------------------------------------------------------
`define XADDR_TOGGLE_CTRL  16'he683
`define XADDR_RESET        16'h0000
`define XDATA_UNMAPPED     8'h00

// ----------------------------------------------------------------
// Toggle control fields
// ----------------------------------------------------------------
`define TC_Q_BIT           7
`define TC_S_BIT           6
`define TC_R_BIT           5
`define TC_IO_BIT          4
// One bit per endpoint number: 0, 1, 2, 6 and 8 are valid
`define TC_EP_VALID_MASK   16'h0147
`define TC_SEL_RESET       5'h00
`define TOGGLE_RESET       32'h0000_0000

`endif

// ==== rtl/toggle_pkg.sv ====
// Types shared by the indirect toggle access block
package toggle_pkg;

  typedef enum logic [2:0] {
    S_RESET   = 3'b001,
    S_IDLE    = 3'b010,
    S_RELEASE = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t        state;
    logic        wr_s1;
    logic        wr_s2;
    logic        rd_s1;
    logic        rd_s2;
    logic        asel_s1;
    logic        asel_s2;
    logic [7:0]  dat_s1;
    logic [7:0]  dat_s2;
    logic [5:0]  cmd_idx;
    logic [15:0] xaddr;
    logic [4:0]  sel;
    logic [31:0] toggle;
    logic [7:0]  rd_data;
    logic        ready;
    logic        int_pend;
    logic        int_n;
    logic        oe;
  } core_t;

  typedef struct packed {
    logic       phase;
    logic [3:0] hi;
    logic       valid;
    logic [7:0] byte_val;
  } nib_t;

endpackage

// ==== rtl/nibble_assembler.sv ====
// Joins two command data nibbles, upper first, into one byte
`include "toggle_cfg.svh"

module nibble_assembler
  import toggle_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clear_in,
  input  wire logic       nib_valid_in,
  input  wire logic [3:0] nibble_in,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out
);

  nib_t q;
  nib_t d;

  always_comb begin
    d       = q;
    d.valid = 1'b0;
    if (clear_in) begin
      d.phase = 1'b0;
    end else if (nib_valid_in && !q.phase) begin
      d.hi    = nibble_in;
      d.phase = 1'b1;
    end else if (nib_valid_in) begin
      d.byte_val = {q.hi, nibble_in};
      d.valid    = 1'b1;
      d.phase    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign byte_valid_out = q.valid;
  assign byte_out       = q.byte_val;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_nibble_order: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (nib_valid_in && q.phase && !clear_in) |=> (q.valid && q.byte_val[3:0] == $past(nibble_in)
      && q.byte_val[7:4] == $past(q.hi)))
    else $error("nibbles not joined upper first");

endmodule // nibble_assembler

// ==== rtl/toggle_reset_indirect_access.sv ====
// Command port with indirect extended-register access to endpoint data toggles
//
// Overview of operation
// - Writing one to bit 5 forces the selected endpoint toggle to DATA0.
// - Bit 4 picks direction: zero means OUT endpoint, one means IN.
// - Bits 3..0 hold endpoint number; only 0, 1, 2, 6, 8 act.
// - A value written through register 3c lands in the addressed extended register.
// - A command address read of 3c returns the addressed register's contents.
// - Each byte arrives as two data nibbles, upper first, joined in order.
// - Active-high ready gates command accesses and is low by default.
// - Active-low interrupt flags pending events and idles high.
// - Low reset returns command port and all toggle settings to defaults.
// - Writing one to bit 6 with bit 5 zero forces the selected endpoint toggle to DATA1.
// - Reading bit 7 returns the selected endpoint's current toggle.
// - Toggle control lives at extended address e683, reached only indirectly.
`include "toggle_cfg.svh"

module toggle_reset_indirect_access
  import toggle_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wr_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        addr_sel_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        txn_done_in,
  input  wire logic        txn_dir_in,
  input  wire logic [3:0]  txn_ep_in,
  output logic [7:0]       data_out,
  output logic             data_oe_out,
  output logic             ready_out,
  output logic             int_n_out,
  output logic [31:0]      toggle_out
);

  localparam core_t CORE_RST = '{
    state:    S_RESET,
    wr_s1:    1'b1,
    wr_s2:    1'b1,
    rd_s1:    1'b1,
    rd_s2:    1'b1,
    xaddr:    `XADDR_RESET,
    sel:      `TC_SEL_RESET,
    toggle:   `TOGGLE_RESET,
    int_n:    1'b1,
    default:  '0
  };

  // One bit per endpoint number, so the lookup stays one bit wide
  localparam logic [15:0] EP_VALID_MASK = `TC_EP_VALID_MASK;

  core_t       q;
  core_t       d;
  logic        nib_valid;
  logic        nib_clear;
  logic        byte_valid;
  logic [7:0]  byte_val;
  logic        tc_wr;
  logic        ep_ok;
  logic        clr_req;
  logic        set_req;
  logic        force_evt;
  logic        rd_clear;
  logic [7:0]  cur_val;
  logic [31:0] tog_next;
  logic        addr_rd_req;

  // ----------------------------------------------------------------
  // Nibble pairing
  // ----------------------------------------------------------------
  nibble_assembler u_nib (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .clear_in       (nib_clear),
    .nib_valid_in   (nib_valid),
    .nibble_in      (q.dat_s2[3:0]),
    .byte_valid_out (byte_valid),
    .byte_out       (byte_val)
  );

  // ----------------------------------------------------------------
  // Toggle control decode
  // ----------------------------------------------------------------
  // Only the toggle control word is mapped; other addresses swallow writes
  assign tc_wr = byte_valid && (q.cmd_idx == `CMD_IDX_VALUE)
                 && (q.xaddr == `XADDR_TOGGLE_CTRL);
  assign ep_ok = EP_VALID_MASK[byte_val[3:0]];
  // Clear takes priority when both action bits are written at once
  assign clr_req   = tc_wr && ep_ok && byte_val[`TC_R_BIT];
  assign set_req   = tc_wr && ep_ok && byte_val[`TC_S_BIT] && !byte_val[`TC_R_BIT];
  assign force_evt = clr_req || set_req;

  assign cur_val = (q.xaddr == `XADDR_TOGGLE_CTRL)
                   ? {q.toggle[q.sel], 2'b00, q.sel}
                   : `XDATA_UNMAPPED;

  assign addr_rd_req = q.asel_s2 && q.dat_s2[`CMD_RD_BIT]
                       && (q.dat_s2[5:0] == `CMD_IDX_VALUE);

  // Index is {direction, endpoint}, so IN entries sit in the upper half
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_tog
      always_comb begin
        if (clr_req && byte_val[4:0] == 5'(gi)) begin
          tog_next[gi] = 1'b0;
        end else if (set_req && byte_val[4:0] == 5'(gi)) begin
          tog_next[gi] = 1'b1;
        end else if (txn_done_in && {txn_dir_in, txn_ep_in} == 5'(gi)) begin
          tog_next[gi] = ~q.toggle[gi];
        end else begin
          tog_next[gi] = q.toggle[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    nib_valid = 1'b0;
    nib_clear = 1'b0;
    rd_clear  = 1'b0;
    // Pins are asynchronous to the core; data is caught at the same depth
    d.wr_s1   = wr_n_in;
    d.wr_s2   = q.wr_s1;
    d.rd_s1   = rd_n_in;
    d.rd_s2   = q.rd_s1;
    d.asel_s1 = addr_sel_in;
    d.asel_s2 = q.asel_s1;
    d.dat_s1  = data_in;
    d.dat_s2  = q.dat_s1;
    d.toggle  = tog_next;
    case (q.state)
      S_RESET: begin
        d.state = S_IDLE;
      end
      S_IDLE: begin
        if (!q.wr_s2) begin
          if (q.asel_s2) begin
            d.cmd_idx = q.dat_s2[5:0];
            nib_clear = 1'b1;
            if (addr_rd_req) begin
              d.rd_data = cur_val;
            end
          end else begin
            nib_valid = 1'b1;
          end
          d.state = S_RELEASE;
        end else if (!q.rd_s2) begin
          d.oe     = 1'b1;
          rd_clear = 1'b1;
          d.state  = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (q.wr_s2 && q.rd_s2) begin
          d.oe    = 1'b0;
          d.state = S_IDLE;
        end
      end
      default: begin
        d.state = S_RESET;
      end
    endcase
    if (byte_valid) begin
      case (q.cmd_idx)
        `CMD_IDX_ADDR_LOW: begin
          d.xaddr[7:0] = byte_val;
        end
        `CMD_IDX_ADDR_HIGH: begin
          d.xaddr[15:8] = byte_val;
        end
        default: begin
        end
      endcase
    end
    if (tc_wr) begin
      d.sel = byte_val[4:0];
    end
    // A new event in the clearing cycle keeps the interrupt pending
    d.int_pend = (q.int_pend && !rd_clear) || force_evt;
    d.int_n    = !d.int_pend;
    d.ready    = (d.state == S_IDLE);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign data_out    = q.rd_data;
  assign data_oe_out = q.oe;
  assign ready_out   = q.ready;
  assign int_n_out   = q.int_n;
  assign toggle_out  = q.toggle;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clear_to_data0: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tc_wr && byte_val[`TC_R_BIT] && (byte_val[3:0] == 4'h6))
      |=> (q.toggle[$past(byte_val[4:0])] == 1'b0))
    else $error("clear did not force data0");

  a_set_to_data1: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tc_wr && byte_val[`TC_S_BIT] && !byte_val[`TC_R_BIT] && (byte_val[3:0] == 4'h2))
      |=> (q.toggle[$past(byte_val[4:0])] == 1'b1))
    else $error("set did not force data1");

  a_dir_other_kept: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clr_req && !txn_done_in)
      |=> (q.toggle[{!$past(byte_val[4]), $past(byte_val[3:0])}]
           == $past(q.toggle[{!byte_val[4], byte_val[3:0]}])))
    else $error("action hit the other direction");

  a_bad_ep_ignored: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tc_wr && !txn_done_in && (byte_val[3:0] == 4'h3 || byte_val[3:0] == 4'h4))
      |=> (q.toggle == $past(q.toggle)) && q.int_n == $past(q.int_n) || $past(rd_clear))
    else $error("invalid endpoint changed a toggle");

  a_low_byte_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (byte_valid && q.cmd_idx == `CMD_IDX_ADDR_LOW)
      |=> (q.xaddr[7:0] == $past(byte_val)) && (q.xaddr[15:8] == $past(q.xaddr[15:8])))
    else $error("low address byte not loaded");

  a_high_byte_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (byte_valid && q.cmd_idx == `CMD_IDX_ADDR_HIGH)
      |=> (q.xaddr[15:8] == $past(byte_val)) && (q.xaddr[7:0] == $past(q.xaddr[7:0])))
    else $error("high address byte not loaded");

  a_value_stored: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tc_wr |=> (q.sel == $past(byte_val[4:0])))
    else $error("value not stored in toggle control");

  a_readback_value: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (q.state == S_IDLE && !q.wr_s2 && addr_rd_req && q.xaddr == `XADDR_TOGGLE_CTRL)
      |=> (q.rd_data[4:0] == $past(q.sel)) && (q.rd_data[`TC_Q_BIT] == $past(q.toggle[q.sel]))
          && (q.rd_data[6:5] == 2'b00))
    else $error("readback differs from toggle control");

  a_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (q.state == S_IDLE && !q.wr_s2 && addr_rd_req && q.xaddr != `XADDR_TOGGLE_CTRL)
      |=> (q.rd_data == `XDATA_UNMAPPED))
    else $error("unmapped extended address read nonzero");

  a_ready_busy_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!q.wr_s2 && (q.state == S_IDLE || q.state == S_RELEASE)) |=> !ready_out)
    else $error("ready high during an access");

  a_event_interrupt: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    force_evt |=> !int_n_out ##1 (!int_n_out || $past(rd_clear)))
    else $error("forced toggle did not raise interrupt");

  a_reset_defaults: assert property (@(posedge sys_clk_in)
    !rst_n_in |=> (!ready_out && int_n_out && toggle_out == `TOGGLE_RESET && !data_oe_out
                   && q.xaddr == `XADDR_RESET))
    else $error("reset left state behind");

  a_addr_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !byte_valid |=> $stable(q.xaddr))
    else $error("extended address changed without a load");

endmodule // toggle_reset_indirect_access

// ==== tb/master_model.sv ====
// Behavioural external master for the nibble-wide command bus
module master_model (
  input  wire logic       sys_clk_in,
  input  wire logic       ready_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic            asel_out,
  output logic [7:0]      data_out,
  output logic            to_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    asel_out = 1'b0;
    data_out = 8'h00;
    to_out   = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Bounded wait for a ready level; a miss raises the timeout flag
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ready_in !== lvl && n < 64);
    if (ready_in !== lvl) to_out <= 1'b1;
  endtask

  // Strobe held until ready drops; a released bus shows the inverse, not the old value
  task automatic access(input logic asel, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
    wait_rdy(1'b1);
    asel_out <= asel;
    data_out <= rd ? ~data_out : d;
    wr_n_out <= rd;
    rd_n_out <= ~rd;
    wait_rdy(1'b0);
    q = oe_in ? rdata_in : 8'hxx;
    wr_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    data_out <= ~data_out;
    wait_rdy(1'b1);
  endtask

  task automatic put_byte(input logic [7:0] b);
    logic [7:0] q;
    access(1'b0, 1'b0, {4'h0, b[7:4]}, q);
    access(1'b0, 1'b0, {4'h0, b[3:0]}, q);
  endtask

  task automatic set_addr(input logic [15:0] a);
    logic [7:0] q;
    access(1'b1, 1'b0, 8'h3a, q);
    put_byte(a[7:0]);
    access(1'b1, 1'b0, 8'h3b, q);
    put_byte(a[15:8]);
  endtask

  task automatic put_val(input logic [7:0] v);
    logic [7:0] q;
    access(1'b1, 1'b0, 8'h3c, q);
    put_byte(v);
  endtask

  task automatic get_val(output logic [7:0] v);
    logic [7:0] q;
    access(1'b1, 1'b0, 8'h7c, q);
    access(1'b0, 1'b1, 8'h00, v);
  endtask
endmodule // master_model

// ==== tb/tb_toggle_reset_indirect_access.sv ====
// Self-checking bench for the indirect toggle access block
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end

module tb_toggle_reset_indirect_access;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst_n;
  logic        wr_n, rd_n, asel, txn_done, txn_dir, data_oe, ready, int_n, to;
  logic [3:0]  txn_ep;
  logic [7:0]  wdata, rdata, q;
  logic [31:0] toggle, exp_t;
  logic [4:0]  sel;
  logic        s;
  int          mismatches;
  int          tests_run;

  toggle_reset_indirect_access dut_u (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
    .addr_sel_in(asel), .data_in(wdata), .txn_done_in(txn_done), .txn_dir_in(txn_dir),
    .txn_ep_in(txn_ep), .data_out(rdata), .data_oe_out(data_oe), .ready_out(ready),
    .int_n_out(int_n), .toggle_out(toggle));

  master_model mm_u (
    .sys_clk_in(sys_clk), .ready_in(ready), .oe_in(data_oe), .rdata_in(rdata),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .asel_out(asel), .data_out(wdata), .to_out(to));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic ep_ok(input logic [3:0] ep);
    return ep inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h8};
  endfunction

  function automatic logic [7:0] ctl_word(input logic [31:0] t, input logic [4:0] sl);
    return {t[sl], 2'b00, sl};
  endfunction

  // One-cycle completion from the USB engine flips one toggle
  task automatic pulse(input logic d, input logic [3:0] ep);
    @(posedge sys_clk);
    txn_done <= 1'b1;
    txn_dir  <= d;
    txn_ep   <= ep;
    @(posedge sys_clk);
    txn_done <= 1'b0;
    txn_ep   <= ~ep;
    exp_t[{d, ep}] = ~exp_t[{d, ep}];
    // The flip lands on the edge just passed; look one edge later
    @(posedge sys_clk);
  endtask

  task automatic stop_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (to === 1'b1) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    txn_done = 1'b0;
    txn_dir = 1'b0;
    txn_ep = 4'h0;
    exp_t = 32'h0000_0000;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(31));
    repeat (2) @(posedge sys_clk);
    `CHK(ready, 1'b0)
    `CHK(int_n, 1'b1)
    `CHK(data_oe, 1'b0)
    `CHK(toggle, exp_t)
    rst_n <= 1'b1;
    mm_u.set_addr(16'he683);
    mm_u.put_val(8'h16);
    mm_u.get_val(q);
    `CHK(q, 8'h16)
    pulse(1'b1, 4'h6);
    `CHK(toggle, exp_t)
    mm_u.get_val(q);
    `CHK(q, 8'h96)
    mm_u.put_val(8'h36);
    exp_t[22] = 1'b0;
    `CHK(toggle, exp_t)
    `CHK(int_n, 1'b0)
    mm_u.get_val(q);
    `CHK(int_n, 1'b1)
    `CHK(q, 8'h16)
    // Random selections, valid and invalid, without reloading the address
    for (int i = 0; i < 24; i++) begin
      sel = 5'($urandom_range(0, 31));
      s = 1'($urandom);
      if ($urandom_range(0, 2) == 0) pulse(1'($urandom), 4'($urandom));
      mm_u.put_val({3'b000, sel});
      mm_u.put_val({1'b0, s, ~s, sel});
      if (ep_ok(sel[3:0])) exp_t[sel] = s;
      `CHK(toggle, exp_t)
      mm_u.get_val(q);
      `CHK(q, ctl_word(exp_t, sel))
    end
    // Unmapped extended address: write ignored, read gives zero
    mm_u.set_addr(16'h1234);
    mm_u.put_val(8'h56);
    mm_u.get_val(q);
    `CHK(q, 8'h00)
    `CHK(toggle, exp_t)
    mm_u.set_addr(16'he683);
    mm_u.get_val(q);
    `CHK(q, ctl_word(exp_t, sel))
    // Reset in mid-run clears toggles, selection and loaded address
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(toggle, 32'h0000_0000)
    `CHK(ready, 1'b0)
    rst_n <= 1'b1;
    mm_u.get_val(q);
    `CHK(q, 8'h00)
    stop_test();
  end
endmodule // tb_toggle_reset_indirect_access
